// ===== qdsl_pkg.sv
// Operation
// - Device shifts 24-bit frames in, MSB first
// - Data bit sampled on serial clock falling edge
// - Check enabled adds eight check bits, 32 total
// - Strobe low during frame updates on select rise
// - Strobe high keeps only first write pending
// - Strobe falling after frame updates all channels holding a pending code
// - Loop outputs stay disabled until explicitly enabled
// - Codes are unsigned straight binary only
// - Top four bits thermometer, low twelve ladder
// - Three ranges per channel via control word
// - Current is span times code over 65536, plus the 4 mA pedestal in the 4-20 range
// - Four separate 16-bit channel data registers
package qdsl_pkg;
    localparam int NCH = 4;
    localparam int CH_W = 2;
    localparam int CODE_W = 16;
    localparam int WORD_W = 24;
    localparam int PEC_W = 8;
    localparam int FRAME_PEC_W = 32;
    localparam int CNT_W = 6;
    localparam int TOP_W = 4;
    localparam int SEG_W = 15;
    localparam int LAD_W = 12;
    localparam int CUR_W = 32;
    localparam int PROD_W = 48;

    // Frame word fields
    localparam int SEL_HI = 23;
    localparam int SEL_LO = 21;
    localparam int CH_HI = 17;
    localparam int CH_LO = 16;
    localparam logic [2:0] SEL_DATA = 3'h0;
    localparam logic [2:0] SEL_CTRL = 3'h1;
    localparam int RANGE_HI = 1;
    localparam int RANGE_LO = 0;
    localparam int OUTEN_BIT = 2;

    // Frame lengths as counter values
    localparam logic [CNT_W-1:0] LEN_PLAIN = 6'h18;
    localparam logic [CNT_W-1:0] LEN_PEC = 6'h20;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3F;

    // Link signal positions inside the synchroniser vectors
    localparam int IX_SCLK = 3;
    localparam int IX_SYNC = 2;
    localparam int IX_SDIN = 1;
    localparam int IX_LOAD = 0;

    // Check code generator
    localparam logic [PEC_W-1:0] CRC_POLY = 8'h07;
    localparam logic [PEC_W-1:0] CRC_INIT = 8'h00;

    // Output ranges
    typedef enum logic [1:0] {
        QDSL_R0_20 = 2'h0,
        QDSL_R0_24 = 2'h1,
        QDSL_R4_20 = 2'h2
    } qdsl_range_e;
    localparam logic [CUR_W-1:0] SPAN_20_NA = 32'h01312D00;
    localparam logic [CUR_W-1:0] SPAN_24_NA = 32'h016E3600;
    localparam logic [CUR_W-1:0] SPAN_16_NA = 32'h00F42400;
    localparam logic [CUR_W-1:0] PED_4_NA = 32'h003D0900;

    // Timing of the host end
    localparam int CLK_MHZ = 100;
    localparam int SCLK_HALF_NS = 40;
    localparam int GAP_NS = 80;
    localparam int LOAD_PULSE_NS = 80;
    localparam int TMR_W = 8;
    localparam logic [TMR_W-1:0] HALF_CYC = TMR_W'((SCLK_HALF_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TMR_W-1:0] GAP_CYC = TMR_W'((GAP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TMR_W-1:0] LOAD_CYC = TMR_W'((LOAD_PULSE_NS * CLK_MHZ + 999) / 1000);

    // Check code over one 24-bit word, MSB first
    function automatic logic [PEC_W-1:0] crc8(input logic [WORD_W-1:0] d);
        logic [PEC_W-1:0] c;
        c = CRC_INIT;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            c = (c[PEC_W-1] ^ d[i]) ? ({c[PEC_W-2:0], 1'b0} ^ CRC_POLY) : {c[PEC_W-2:0], 1'b0};
        end
        return c;
    endfunction
endpackage

// ===== qdsl_link_if.sv
`timescale 1ns/10ps
// Three-wire link plus load strobe between host and converter
interface qdsl_link_if;
    logic sclk;
    logic sync_n;
    logic sdin;
    logic load_strobe_n;

    modport host (
        output sclk,
        output sync_n,
        output sdin,
        output load_strobe_n
    );
    modport dev (
        input sclk,
        input sync_n,
        input sdin,
        input load_strobe_n
    );
endinterface

// ===== qdsl_dev.sv
`timescale 1ns/10ps
// Converter end: serial load, update control, code split and current
module qdsl_dev (
    input wire logic ref_clk, // System clock
    input wire logic arst_n, // Async reset
    qdsl_link_if.dev link, // Serial link from host
    input wire logic pec_enable, // Check bits expected
    output logic [qdsl_pkg::NCH-1:0][qdsl_pkg::CUR_W-1:0] loop_current_na, // Current in nA
    output logic [qdsl_pkg::NCH-1:0] loop_current_output, // Output driven, else high-z
    output logic [qdsl_pkg::NCH-1:0][qdsl_pkg::SEG_W-1:0] segment_switches, // Segment controls
    output logic [qdsl_pkg::NCH-1:0][qdsl_pkg::LAD_W-1:0] ladder_switches, // Ladder controls
    output logic frame_done, // Good frame taken
    output logic frame_error // Frame dropped
);
    // Synchronisers and edge history
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    logic sclk_fall;
    logic sync_low;
    logic sync_rise;
    logic load_fall;
    logic load_low;

    // Shift state
    logic [qdsl_pkg::FRAME_PEC_W-1:0] shift_r;
    logic [qdsl_pkg::FRAME_PEC_W-1:0] shift_nxt;
    logic [qdsl_pkg::CNT_W-1:0] cnt_r;
    logic [qdsl_pkg::CNT_W-1:0] cnt_nxt;

    // Frame decode
    logic [qdsl_pkg::WORD_W-1:0] word;
    logic [qdsl_pkg::CNT_W-1:0] frame_len;
    logic crc_ok;
    logic frame_ok;
    logic frame_bad;
    logic [qdsl_pkg::CH_W-1:0] ch;
    logic [2:0] sel;
    logic [qdsl_pkg::CODE_W-1:0] code;

    // Channel state
    logic [qdsl_pkg::NCH-1:0][qdsl_pkg::CODE_W-1:0] data_r;
    logic [qdsl_pkg::NCH-1:0][qdsl_pkg::CODE_W-1:0] data_nxt;
    logic [qdsl_pkg::NCH-1:0][qdsl_pkg::CODE_W-1:0] pend_r;
    logic [qdsl_pkg::NCH-1:0][qdsl_pkg::CODE_W-1:0] pend_nxt;
    logic [qdsl_pkg::NCH-1:0][qdsl_pkg::CODE_W-1:0] act_r;
    logic [qdsl_pkg::NCH-1:0][qdsl_pkg::CODE_W-1:0] act_nxt;
    logic [qdsl_pkg::NCH-1:0] held_r;
    logic [qdsl_pkg::NCH-1:0] held_nxt;
    logic [qdsl_pkg::NCH-1:0][1:0] range_r;
    logic [qdsl_pkg::NCH-1:0][1:0] range_nxt;
    logic [qdsl_pkg::NCH-1:0] oen_r;
    logic [qdsl_pkg::NCH-1:0] oen_nxt;

    // Output next values
    logic [qdsl_pkg::NCH-1:0][qdsl_pkg::CUR_W-1:0] cur_nxt;
    logic [qdsl_pkg::NCH-1:0][qdsl_pkg::SEG_W-1:0] seg_nxt;
    logic [qdsl_pkg::NCH-1:0][qdsl_pkg::LAD_W-1:0] lad_nxt;
    logic done_nxt;
    logic err_nxt;

    // Two flip-flops on every link pin, third stage only for edges
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= 4'hD;
            s2_r <= 4'hD;
            s3_r <= 4'hD;
        end else begin
            s1_r <= {link.sclk, link.sync_n, link.sdin, link.load_strobe_n};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Edge and level detection on synchronised link signals
    assign sclk_fall = s3_r[qdsl_pkg::IX_SCLK] & ~s2_r[qdsl_pkg::IX_SCLK];
    assign sync_low = ~s2_r[qdsl_pkg::IX_SYNC];
    assign sync_rise = ~s3_r[qdsl_pkg::IX_SYNC] & s2_r[qdsl_pkg::IX_SYNC];
    assign load_fall = s3_r[qdsl_pkg::IX_LOAD] & ~s2_r[qdsl_pkg::IX_LOAD];
    assign load_low = ~s2_r[qdsl_pkg::IX_LOAD];

    // Shift register fills MSB first while select is low
    always_comb begin
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        if (!sync_low) begin
            cnt_nxt = '0;
        end else if (sclk_fall) begin
            shift_nxt = {shift_r[qdsl_pkg::FRAME_PEC_W-2:0], s2_r[qdsl_pkg::IX_SDIN]};
            if (cnt_r != qdsl_pkg::CNT_MAX) begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_r <= '0;
            cnt_r <= '0;
        end else begin
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Frame length and check code, judged when select rises
    always_comb begin
        frame_len = pec_enable ? qdsl_pkg::LEN_PEC : qdsl_pkg::LEN_PLAIN;
        word = pec_enable ? shift_r[qdsl_pkg::FRAME_PEC_W-1:qdsl_pkg::PEC_W]
                          : shift_r[qdsl_pkg::WORD_W-1:0];
        crc_ok = !pec_enable || (qdsl_pkg::crc8(word) == shift_r[qdsl_pkg::PEC_W-1:0]);
        frame_ok = sync_rise && (cnt_r == frame_len) && crc_ok;
        frame_bad = sync_rise && (cnt_r != '0) && !frame_ok;
        ch = word[qdsl_pkg::CH_HI:qdsl_pkg::CH_LO];
        sel = word[qdsl_pkg::SEL_HI:qdsl_pkg::SEL_LO];
        code = word[qdsl_pkg::CODE_W-1:0];
    end

    // Data, pending and active codes per channel
    always_comb begin
        data_nxt = data_r;
        pend_nxt = pend_r;
        act_nxt = act_r;
        held_nxt = held_r;
        range_nxt = range_r;
        oen_nxt = oen_r;
        if (load_fall) begin
            for (int i = 0; i < qdsl_pkg::NCH; i++) begin
                if (held_r[i]) begin
                    act_nxt[i] = pend_r[i];
                end
            end
            held_nxt = '0;
        end
        if (frame_ok && sel == qdsl_pkg::SEL_DATA) begin
            data_nxt[ch] = code;
            if (load_low) begin
                act_nxt[ch] = code;
            end else if (!held_r[ch]) begin
                pend_nxt[ch] = code;
                held_nxt[ch] = 1'b1;
            end
        end else if (frame_ok && sel == qdsl_pkg::SEL_CTRL) begin
            range_nxt[ch] = code[qdsl_pkg::RANGE_HI:qdsl_pkg::RANGE_LO];
            oen_nxt[ch] = code[qdsl_pkg::OUTEN_BIT];
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_r <= '0;
            pend_r <= '0;
            act_r <= '0;
            held_r <= '0;
            range_r <= '0;
            oen_r <= '0;
        end else begin
            data_r <= data_nxt;
            pend_r <= pend_nxt;
            act_r <= act_nxt;
            held_r <= held_nxt;
            range_r <= range_nxt;
            oen_r <= oen_nxt;
        end
    end

    // Code split into switch controls and current per range
    always_comb begin
        logic [qdsl_pkg::CUR_W-1:0] span;
        logic [qdsl_pkg::CUR_W-1:0] ped;
        logic [qdsl_pkg::PROD_W-1:0] prod;
        span = '0;
        ped = '0;
        prod = '0;
        cur_nxt = '0;
        seg_nxt = '0;
        lad_nxt = '0;
        for (int i = 0; i < qdsl_pkg::NCH; i++) begin
            for (int j = 0; j < qdsl_pkg::SEG_W; j++) begin
                seg_nxt[i][j] = (act_r[i][qdsl_pkg::CODE_W-1:qdsl_pkg::LAD_W]
                                 > qdsl_pkg::TOP_W'(j));
            end
            lad_nxt[i] = act_r[i][qdsl_pkg::LAD_W-1:0];
            case (range_r[i])
                qdsl_pkg::QDSL_R0_24: begin
                    span = qdsl_pkg::SPAN_24_NA;
                    ped = '0;
                end
                qdsl_pkg::QDSL_R4_20: begin
                    span = qdsl_pkg::SPAN_16_NA;
                    ped = qdsl_pkg::PED_4_NA;
                end
                default: begin
                    span = qdsl_pkg::SPAN_20_NA;
                    ped = '0;
                end
            endcase
            prod = qdsl_pkg::PROD_W'(span) * qdsl_pkg::PROD_W'(act_r[i]);
            if (oen_r[i]) begin
                cur_nxt[i] = prod[qdsl_pkg::PROD_W-1:qdsl_pkg::CODE_W] + ped;
            end
        end
        done_nxt = frame_ok;
        err_nxt = frame_bad;
    end

    // Registered outputs
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            loop_current_na <= '0;
            loop_current_output <= '0;
            segment_switches <= '0;
            ladder_switches <= '0;
            frame_done <= 1'b0;
            frame_error <= 1'b0;
        end else begin
            loop_current_na <= cur_nxt;
            loop_current_output <= oen_r;
            segment_switches <= seg_nxt;
            ladder_switches <= lad_nxt;
            frame_done <= done_nxt;
            frame_error <= err_nxt;
        end
    end
endmodule

// ===== qdsl_host.sv
`timescale 1ns/10ps
// Host end: frames words onto the link and drives the load strobe
module qdsl_host (
    input wire logic ref_clk, // System clock
    input wire logic arst_n, // Async reset
    qdsl_link_if.host link, // Serial link to converter
    input wire logic pec_enable, // Append check bits
    input wire logic cmd_valid, // Word offered
    input wire logic [qdsl_pkg::WORD_W-1:0] cmd_word, // Word to send
    input wire logic cmd_individual, // Hold strobe low for this word
    input wire logic update_req, // Pulse strobe to update all
    output logic cmd_ready // Idle, request taken
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_HIGH = 3'b001,
        H_LOW = 3'b011,
        H_END = 3'b010,
        H_GAP = 3'b110,
        H_LOAD = 3'b111
    } qdsl_hst_e;

    qdsl_hst_e st_r, st_nxt;
    logic [qdsl_pkg::TMR_W-1:0] tmr_r, tmr_nxt;
    logic [qdsl_pkg::CNT_W-1:0] left_r, left_nxt;
    logic [qdsl_pkg::FRAME_PEC_W-1:0] frm_r, frm_nxt;
    logic sclk_r, sclk_nxt;
    logic sync_n_r, sync_n_nxt;
    logic sdin_r, sdin_nxt;
    logic load_n_r, load_n_nxt;
    logic rdy_r, rdy_nxt;

    assign link.sclk = sclk_r;
    assign link.sync_n = sync_n_r;
    assign link.sdin = sdin_r;
    assign link.load_strobe_n = load_n_r;
    assign cmd_ready = rdy_r;

    // Sequencer and clock divider
    always_comb begin
        st_nxt = st_r;
        tmr_nxt = tmr_r;
        left_nxt = left_r;
        frm_nxt = frm_r;
        sclk_nxt = sclk_r;
        sync_n_nxt = sync_n_r;
        sdin_nxt = sdin_r;
        load_n_nxt = load_n_r;
        rdy_nxt = rdy_r;
        if (tmr_r != '0) begin
            tmr_nxt = tmr_r - 1'b1;
        end
        case (st_r)
            H_IDLE: begin
                if (cmd_valid && rdy_r) begin
                    frm_nxt = pec_enable ? {cmd_word, qdsl_pkg::crc8(cmd_word)}
                                         : {cmd_word, qdsl_pkg::PEC_W'(0)};
                    left_nxt = pec_enable ? qdsl_pkg::LEN_PEC : qdsl_pkg::LEN_PLAIN;
                    sdin_nxt = cmd_word[qdsl_pkg::WORD_W-1];
                    sync_n_nxt = 1'b0;
                    load_n_nxt = !cmd_individual;
                    tmr_nxt = qdsl_pkg::HALF_CYC - 1'b1;
                    rdy_nxt = 1'b0;
                    st_nxt = H_HIGH;
                end else if (update_req && rdy_r) begin
                    load_n_nxt = 1'b0;
                    tmr_nxt = qdsl_pkg::LOAD_CYC - 1'b1;
                    rdy_nxt = 1'b0;
                    st_nxt = H_LOAD;
                end
            end
            H_HIGH: begin
                if (tmr_r == '0) begin
                    sclk_nxt = 1'b0;
                    tmr_nxt = qdsl_pkg::HALF_CYC - 1'b1;
                    st_nxt = H_LOW;
                end
            end
            H_LOW: begin
                if (tmr_r == '0) begin
                    sclk_nxt = 1'b1;
                    tmr_nxt = qdsl_pkg::HALF_CYC - 1'b1;
                    left_nxt = left_r - 1'b1;
                    frm_nxt = {frm_r[qdsl_pkg::FRAME_PEC_W-2:0], 1'b0};
                    sdin_nxt = frm_r[qdsl_pkg::FRAME_PEC_W-2];
                    st_nxt = (left_r == 6'h01) ? H_END : H_HIGH;
                end
            end
            H_END: begin
                if (tmr_r == '0) begin
                    sync_n_nxt = 1'b1;
                    tmr_nxt = qdsl_pkg::GAP_CYC - 1'b1;
                    st_nxt = H_GAP;
                end
            end
            H_GAP: begin
                if (tmr_r == '0) begin
                    load_n_nxt = 1'b1;
                    rdy_nxt = 1'b1;
                    st_nxt = H_IDLE;
                end
            end
            H_LOAD: begin
                if (tmr_r == '0) begin
                    load_n_nxt = 1'b1;
                    tmr_nxt = qdsl_pkg::GAP_CYC - 1'b1;
                    st_nxt = H_GAP;
                end
            end
            default: begin
                st_nxt = H_IDLE;
                rdy_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= H_IDLE;
            tmr_r <= '0;
            left_r <= '0;
            frm_r <= '0;
            sclk_r <= 1'b1;
            sync_n_r <= 1'b1;
            sdin_r <= 1'b0;
            load_n_r <= 1'b1;
            rdy_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            left_r <= left_nxt;
            frm_r <= frm_nxt;
            sclk_r <= sclk_nxt;
            sync_n_r <= sync_n_nxt;
            sdin_r <= sdin_nxt;
            load_n_r <= load_n_nxt;
            rdy_r <= rdy_nxt;
        end
    end
endmodule

// ===== qdsl_link_monitor.sv
`timescale 1ns/10ps
// Watches the link wires between host end and converter end
module qdsl_link_monitor (
    input wire logic ref_clk, // System clock
    input wire logic arst_n, // Async reset
    input wire logic sclk, // Serial clock
    input wire logic sync_n, // Frame select
    input wire logic sdin, // Serial data
    input wire logic load_strobe_n, // Load strobe
    input wire logic pec_enable // Host appends check bits
);
    logic sclk_r;
    logic sclk_nxt;
    logic sync_r;
    logic sync_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;

    // Counts falling clock edges inside one frame
    always_comb begin
        sclk_nxt = sclk;
        sync_nxt = sync_n;
        cnt_nxt = cnt_r;
        if (sync_r && !sync_n) begin
            cnt_nxt = 6'h00;
        end else if (sclk_r && !sclk && !sync_n) begin
            cnt_nxt = cnt_r + 6'h01;
        end
    end

    // Registers the edge detectors and the counter
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_r <= 1'b1;
            sync_r <= 1'b1;
            cnt_r <= 6'h00;
        end else begin
            sclk_r <= sclk_nxt;
            sync_r <= sync_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    // Clock low half is four cycles, then it rises
    sequence s_low_half;
        !sclk [*4] ##1 sclk;
    endsequence

    // Update pulse of eight cycles outside any frame
    sequence s_update;
        (sync_n && !load_strobe_n) [*8] ##1 (sync_n && load_strobe_n);
    endsequence

    a_idle_clock_high: assert property (sync_n |-> sclk)
        else $error("serial clock low outside a frame");
    a_shift_in_frame: assert property ($fell(sclk) |-> !sync_n)
        else $error("clock edge outside a frame");
    a_bit_stable: assert property ($fell(sclk) |-> $stable(sdin) ##1 $stable(sdin) [*3])
        else $error("data moved around the sampling edge");
    a_low_half_len: assert property ($fell(sclk) |-> s_low_half)
        else $error("clock low half has wrong length");
    a_frame_length: assert property ($rose(sync_n) |->
        cnt_r == (pec_enable ? qdsl_pkg::LEN_PEC : qdsl_pkg::LEN_PLAIN))
        else $error("frame bit count wrong");
    a_strobe_held: assert property (!sync_n && !$past(sync_n) |-> $stable(load_strobe_n))
        else $error("strobe moved inside a frame");
    a_indiv_release: assert property ($rose(sync_n) && !load_strobe_n |->
        sync_n throughout (##[1:10] load_strobe_n))
        else $error("strobe not released after frame");
    a_update_pulse: assert property ($fell(load_strobe_n) && sync_n |-> s_update)
        else $error("update pulse malformed");
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
// Runs both link ends from their user sides and checks converter outputs
module tb_top;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic pec_host = 1'b0;
    logic pec_dev = 1'b0;
    logic cmd_valid = 1'b0;
    logic [23:0] cmd_word = 24'h000000;
    logic cmd_individual = 1'b0;
    logic update_req = 1'b0;
    logic cmd_ready;
    logic frame_error;
    logic frame_done;
    logic [3:0][31:0] cur;
    logic [3:0] outen;
    logic [3:0][14:0] seg;
    logic [3:0][11:0] lad;
    logic [15:0] act [4];
    logic [15:0] pend [4];
    logic pv [4];
    logic en_m [4];
    logic [1:0] rng_m [4];
    logic [15:0] corner [4] = '{16'h0000, 16'hFFFF, 16'h1000, 16'h0FFF};
    int fails = 0;
    int checks = 0;
    int seed = 55;
    int cyc = 0;
    int nerr = 0;
    int n0;
    int ndone = 0;
    int ntx = 0;

    qdsl_link_if i_qdsl_link_if ();
    qdsl_host i_qdsl_host (.ref_clk, .arst_n, .link(i_qdsl_link_if), .pec_enable(pec_host),
        .cmd_valid, .cmd_word, .cmd_individual, .update_req, .cmd_ready);
    qdsl_dev i_qdsl_dev (.ref_clk, .arst_n, .link(i_qdsl_link_if), .pec_enable(pec_dev),
        .loop_current_na(cur), .loop_current_output(outen), .segment_switches(seg),
        .ladder_switches(lad), .frame_done, .frame_error);
    qdsl_link_monitor i_qdsl_link_monitor (.ref_clk, .arst_n, .sclk(i_qdsl_link_if.sclk),
        .sync_n(i_qdsl_link_if.sync_n), .sdin(i_qdsl_link_if.sdin),
        .load_strobe_n(i_qdsl_link_if.load_strobe_n), .pec_enable(pec_host));

    // Clock and hang guard
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (frame_error === 1'b1) begin
            nerr++;
        end
        if (frame_done === 1'b1) begin
            ndone++;
        end
        if (cyc == 20000) begin
            fails++;
            close_out;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Expected loop current in nA for a code and range
    function automatic logic [31:0] exp_cur(input logic en, input logic [1:0] r,
        input logic [15:0] c);
        logic [47:0] p;
        p = 48'(c) * 48'((r == 2'h1) ? qdsl_pkg::SPAN_24_NA :
            (r == 2'h2) ? qdsl_pkg::SPAN_16_NA : qdsl_pkg::SPAN_20_NA);
        return en ? (p[47:16] + ((r == 2'h2) ? qdsl_pkg::PED_4_NA : 32'h00000000)) : 32'h0;
    endfunction

    // Expected thermometer of the top nibble
    function automatic logic [14:0] exp_seg(input logic [15:0] c);
        logic [14:0] s;
        for (int j = 0; j < 15; j++) begin
            s[j] = c[15:12] > j;
        end
        return s;
    endfunction

    task automatic idle;
        while (cmd_ready !== 1'b1) @(negedge ref_clk);
    endtask

    // One word across the link, then settle
    task automatic tx(input logic [23:0] w, input logic ind);
        idle;
        cmd_word = w;
        cmd_individual = ind;
        cmd_valid = 1'b1;
        ntx++;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        check(32'(cmd_ready), 32'h0);
        idle;
        repeat (6) @(negedge ref_clk);
    endtask

    // Model state after any reset
    task automatic clr_model;
        for (int i = 0; i < 4; i++) begin
            act[i] = 16'h0;
            pv[i] = 1'b0;
            en_m[i] = 1'b0;
            rng_m[i] = 2'h0;
        end
    endtask

    // Strobe fall moves pending codes to the outputs
    task automatic copy_pend;
        for (int i = 0; i < 4; i++) begin
            if (pv[i]) begin
                act[i] = pend[i];
                pv[i] = 1'b0;
            end
        end
    endtask

    task automatic wr(input logic [1:0] ch, input logic [15:0] code, input logic ind);
        tx({3'h0, 3'h0, ch, code}, ind);
        if (ind) begin
            copy_pend;
            act[ch] = code;
        end else if (!pv[ch]) begin
            pend[ch] = code;
            pv[ch] = 1'b1;
        end
    endtask

    task automatic ctl(input logic [1:0] ch, input logic en, input logic [1:0] r);
        tx({3'h1, 3'h0, ch, 13'h0, en, r}, 1'b0);
        en_m[ch] = en;
        rng_m[ch] = r;
    endtask

    task automatic upd;
        idle;
        update_req = 1'b1;
        @(negedge ref_clk);
        update_req = 1'b0;
        idle;
        repeat (6) @(negedge ref_clk);
        copy_pend;
    endtask

    task automatic chk_all;
        for (int c = 0; c < 4; c++) begin
            check(32'(outen[c]), 32'(en_m[c]));
            check(cur[c], exp_cur(en_m[c], rng_m[c], act[c]));
            check(32'(seg[c]), 32'(exp_seg(act[c])));
            check(32'(lad[c]), 32'(act[c][11:0]));
        end
    endtask

    // Main sequence
    initial begin
        clr_model;
        repeat (6) @(negedge ref_clk);
        arst_n = 1'b1;
        @(negedge ref_clk);
        chk_all;
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            ctl(2'(c), 1'b1, 2'(c));
            for (int k = 0; k < 4; k++) begin
                wr(2'(c), corner[k], 1'b1);
                chk_all;
            end
        end
        repeat (8) begin
            wr(2'($random(seed)), 16'($random(seed)), 1'b1);
            chk_all;
        end
        $display("test individual done");
        wr(2'h0, 16'hA5A5, 1'b0);
        wr(2'h0, 16'h5A5A, 1'b0);
        wr(2'h1, 16'($random(seed)), 1'b0);
        chk_all;
        upd;
        chk_all;
        wr(2'h0, 16'h5A5A, 1'b0);
        upd;
        chk_all;
        $display("test simultaneous done");
        pec_host = 1'b1;
        pec_dev = 1'b1;
        repeat (6) begin
            wr(2'($random(seed)), 16'($random(seed)), 1'b1);
            chk_all;
        end
        pec_host = 1'b0;
        n0 = nerr;
        tx({3'h0, 3'h0, 2'h3, 16'h1234}, 1'b1);
        check(32'(nerr - n0), 32'h1);
        chk_all;
        pec_dev = 1'b0;
        $display("test check bits done");
        ctl(2'h2, 1'b0, 2'h2);
        chk_all;
        $display("test disable done");
        arst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        arst_n = 1'b1;
        clr_model;
        repeat (2) @(negedge ref_clk);
        chk_all;
        ctl(2'h1, 1'b1, 2'h1);
        wr(2'h1, 16'($random(seed)), 1'b1);
        chk_all;
        check(32'(ndone), 32'(ntx - 1));
        check(32'(nerr), 32'h1);
        $display("test mid reset done");
        close_out;
    end
endmodule
